// ==== logic/clean_sched_regs.svh ====
// Register offsets, field values and timing counts of the cleaning schedule register slave.
// Assumes the register port delivers one decoded 16-bit register access per request.
// Behaviour
// - Start a clean whenever the local hour equals any of three scheduled slots.
// - Scheduled slots sit at registers 50, 51, 52; multiple-register write accepted.
// - Slots hold 24-hour values; 25 never matches; slots kept in nonvolatile store.
// - Register 13 holds signed hour offset, single-register write, nonvolatile.
// - Registers 20-21 hold 32-bit epoch seconds, multiple-register write, volatile.
// - Epoch count keeps advancing once per second while powered.
// - After reset no scheduled clean until a fresh epoch time is written.
// - Single write of 255 to register 53 starts one clean at once.
// - Register 53 returns to zero when that triggered clean finishes.
// - Registers 40-41 hold epoch time of the latest clean from own count.
// - Pump load and clean time latched after each clean, held until next.
// - Registers 40 to 46 read back the seven-word status block.
// - Reservoir code reads 0 with liquid present, 3 without.
`ifndef CLEAN_SCHED_REGS_SVH
`define CLEAN_SCHED_REGS_SVH

`define ADDR_ZONE_OFFSET      16'h000d
`define ADDR_EPOCH_HI         16'h0014
`define ADDR_EPOCH_LO         16'h0015
`define ADDR_LAST_CLEAN_HI    16'h0028
`define ADDR_LAST_CLEAN_LO    16'h0029
`define ADDR_PUMP_LOAD        16'h002a
`define ADDR_TEMPERATURE      16'h002b
`define ADDR_HUMIDITY         16'h002c
`define ADDR_CELL_VOLTAGE     16'h002d
`define ADDR_RESERVOIR        16'h002e
`define ADDR_HOUR_A           16'h0032
`define ADDR_HOUR_B           16'h0033
`define ADDR_HOUR_C           16'h0034
`define ADDR_TRIGGER          16'h0035

`define FUNC_WRITE_SINGLE     8'h06
`define FUNC_WRITE_MULTI      8'h16

`define TRIGGER_VALUE         16'h00ff
`define SLOT_DISABLED         16'h0019
`define RESERVOIR_WET         16'h0000
`define RESERVOIR_DRY         16'h0003

`define SECONDS_PER_HOUR      12'he10
`define HOURS_PER_DAY         5'h18

`define CORE_CLK_HZ           200000000
`define TICK_PERIOD_S         1
`define TICK_CYCLES           (`CORE_CLK_HZ * `TICK_PERIOD_S)

`endif

// ==== logic/clean_sched_pkg.sv ====
// Types shared by the cleaning schedule register slave and its local hour divider.
// Assumes the widths fixed by clean_sched_regs.svh.
`default_nettype none
package clean_sched_pkg;

  typedef enum logic [0:0] {
    CLEAN_IDLE = 1'b0,
    CLEAN_RUN  = 1'b1
  } clean_state_t;

  typedef struct packed {
    clean_state_t state;
    logic [15:0]  zone;
    logic [15:0]  hour_a;
    logic [15:0]  hour_b;
    logic [15:0]  hour_c;
    logic [15:0]  trigger;
    logic [31:0]  epoch;
    logic [15:0]  epoch_stage;
    logic         stage_valid;
    logic         time_valid;
    logic [31:0]  tick_cnt;
    logic [31:0]  last_time;
    logic [15:0]  pump;
    logic [31:0]  start_time;
    logic         sched_pend;
    logic         now_pend;
    logic         now_active;
    logic [4:0]   hour_seen;
    logic         seen_valid;
    logic         div_start;
    logic [15:0]  rdata;
    logic         ack;
    logic         err;
    logic         nv_store;
  } slave_state_t;

  typedef struct packed {
    logic        busy;
    logic [5:0]  cnt;
    logic [31:0] dividend;
    logic [11:0] rem;
    logic [4:0]  qmod;
    logic [4:0]  hour;
    logic        done;
  } divider_state_t;

endpackage
`default_nettype wire

// ==== logic/hour_calc_if.sv ====
// Handshake between the register slave and the local hour divider.
// Assumes one start at a time; start is ignored while the divider is busy.
`timescale 1ns/1ps
`default_nettype none
interface hour_calc_if;
  logic        start;
  logic [31:0] local_seconds;
  logic        busy;
  logic        done;
  logic [4:0]  hour;

  modport requester (output start, output local_seconds, input busy, input done, input hour);
  modport divider   (input start, input local_seconds, output busy, output done, output hour);
endinterface
`default_nettype wire

// ==== logic/local_hour_divider.sv ====
// Serial divide of local seconds by one hour, keeping the quotient modulo one day.
// Assumes a start pulse with stable local_seconds; result after 33 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "clean_sched_regs.svh"
module local_hour_divider (
  input  wire logic  clk,
  input  wire logic  resetn,
  hour_calc_if.divider calc
);
  clean_sched_pkg::divider_state_t st_reg;
  clean_sched_pkg::divider_state_t st_next;
  logic [12:0] trial;
  logic [5:0]  dbl;

  assign calc.busy = st_reg.busy;
  assign calc.done = st_reg.done;
  assign calc.hour = st_reg.hour;

  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    trial = {st_reg.rem, st_reg.dividend[31]};
    dbl = 6'h00;
    if (!st_reg.busy) begin
      if (calc.start) begin
        st_next.busy = 1'b1;
        st_next.cnt = 6'h00;
        st_next.dividend = calc.local_seconds;
        st_next.rem = 12'h000;
        st_next.qmod = 5'h00;
      end
    end else begin
      // Quotient bits arrive msb first, so the day wrap is folded in at every step
      // and the full quotient is never stored
      st_next.dividend = {st_reg.dividend[30:0], 1'b0};
      if (trial >= {1'b0, `SECONDS_PER_HOUR}) begin
        st_next.rem = 12'(trial - {1'b0, `SECONDS_PER_HOUR});
        dbl = {st_reg.qmod, 1'b1};
      end else begin
        st_next.rem = trial[11:0];
        dbl = {st_reg.qmod, 1'b0};
      end
      // Doubling a residue below 24 needs six bits before the day wrap
      if (dbl >= {1'b0, `HOURS_PER_DAY}) begin
        st_next.qmod = 5'(dbl - {1'b0, `HOURS_PER_DAY});
      end else begin
        st_next.qmod = dbl[4:0];
      end
      st_next.cnt = 6'(st_reg.cnt + 6'h01);
      if (st_reg.cnt == 6'h1f) begin
        st_next.busy = 1'b0;
        st_next.done = 1'b1;
        st_next.hour = st_next.qmod;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  hour_in_day_a: assert property (@(posedge clk) disable iff (!resetn)
    st_reg.done |-> st_reg.hour < `HOURS_PER_DAY) else $error("hour out of day range");
endmodule
`default_nettype wire

// ==== logic/clean_schedule_register_slave.sv ====
// Register bank of the field cleaning controller: time base, schedule and status block.
// Assumes an upstream serial slave hands over one register access per request, one at a time.
`timescale 1ns/1ps
`default_nettype none
`include "clean_sched_regs.svh"
module clean_schedule_register_slave #(
  parameter int unsigned SEC_CYCLES = `TICK_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic        REG_RD,
  input  wire logic        REG_WR,
  input  wire logic [7:0]  REG_FUNC,
  input  wire logic [15:0] REG_ADDR,
  input  wire logic [15:0] REG_WDATA,
  output logic      [15:0] REG_RDATA,
  output logic             REG_ACK,
  output logic             REG_ERR,
  output logic             CLEAN_RUN,
  input  wire logic        CLEAN_DONE,
  input  wire logic [15:0] PUMP_LOAD,
  input  wire logic [15:0] TEMP_IN,
  input  wire logic [15:0] HUMID_IN,
  input  wire logic [15:0] CELL_VOLT_IN,
  input  wire logic        LIQUID_PRESENT,
  input  wire logic [63:0] NV_IMAGE_IN,
  output logic      [63:0] NV_IMAGE,
  output logic             NV_STORE,
  output logic             TIME_VALID
);
  // Below two cycles the second counter would tick on every cycle or only after a full 32-bit wrap
  if (SEC_CYCLES < 2 || SEC_CYCLES > 32'hffff_fffe) begin
    $error("SEC_CYCLES out of range");
  end

  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

  clean_sched_pkg::slave_state_t st_reg;
  clean_sched_pkg::slave_state_t st_next;

  hour_calc_if calc ();

  local_hour_divider u_div (
    .clk    (CORE_CLK),
    .resetn (RESETN),
    .calc   (calc)
  );

  function automatic logic slot_match(input logic [15:0] slot, input logic [4:0] hour);
    slot_match = (slot == {11'h000, hour});
  endfunction

  logic        wr_single;
  logic        wr_multi;
  logic        tick;
  logic        load_time;
  logic        hour_event;
  logic        any_slot;
  logic        trig_write;
  logic [31:0] zone_secs;

  assign wr_single  = REG_WR && (REG_FUNC == `FUNC_WRITE_SINGLE);
  assign wr_multi   = REG_WR && (REG_FUNC == `FUNC_WRITE_MULTI);
  assign tick       = (st_reg.tick_cnt == SEC_LAST);
  assign load_time  = wr_multi && (REG_ADDR == `ADDR_EPOCH_LO) && st_reg.stage_valid;
  assign trig_write = wr_single && (REG_ADDR == `ADDR_TRIGGER);
  // Signed offset times one hour; wraps like the 32-bit epoch itself
  assign zone_secs  = 32'($signed(st_reg.zone) * $signed(17'h00e10));

  assign calc.start         = st_reg.div_start;
  assign calc.local_seconds = 32'(st_reg.epoch + zone_secs);

  // A new hour is judged when the result differs from the last one seen or no hour is held as seen
  assign hour_event = calc.done && (!st_reg.seen_valid || calc.hour != st_reg.hour_seen);
  assign any_slot   = slot_match(st_reg.hour_a, calc.hour)
                    || slot_match(st_reg.hour_b, calc.hour)
                    || slot_match(st_reg.hour_c, calc.hour);

  assign REG_RDATA  = st_reg.rdata;
  assign REG_ACK    = st_reg.ack;
  assign REG_ERR    = st_reg.err;
  assign CLEAN_RUN  = (st_reg.state == clean_sched_pkg::CLEAN_RUN);
  assign NV_IMAGE   = {st_reg.zone, st_reg.hour_a, st_reg.hour_b, st_reg.hour_c};
  assign NV_STORE   = st_reg.nv_store;
  assign TIME_VALID = st_reg.time_valid;

  always_comb begin
    st_next = st_reg;
    st_next.ack = 1'b0;
    st_next.err = 1'b0;
    st_next.nv_store = 1'b0;
    // A start that meets a busy divider waits instead of being lost
    st_next.div_start = st_reg.div_start && calc.busy;

    // Time base keeps running on the internal clock only; drift is accepted
    if (tick) begin
      st_next.tick_cnt = 32'h0000_0000;
      st_next.epoch = 32'(st_reg.epoch + 32'h0000_0001);
      st_next.div_start = 1'b1;
    end else begin
      st_next.tick_cnt = 32'(st_reg.tick_cnt + 32'h0000_0001);
    end

    // Cleaning sequencer; a manual trigger is served before a scheduled request
    case (st_reg.state)
      clean_sched_pkg::CLEAN_IDLE: begin
        if (st_reg.now_pend || st_reg.sched_pend) begin
          st_next.state = clean_sched_pkg::CLEAN_RUN;
          st_next.start_time = st_reg.epoch;
          st_next.now_active = st_reg.now_pend;
          if (st_reg.now_pend) begin
            st_next.now_pend = 1'b0;
          end else begin
            st_next.sched_pend = 1'b0;
          end
        end
      end
      clean_sched_pkg::CLEAN_RUN: begin
        if (CLEAN_DONE) begin
          st_next.state = clean_sched_pkg::CLEAN_IDLE;
          st_next.last_time = st_reg.start_time;
          st_next.pump = PUMP_LOAD;
          if (st_reg.now_active) begin
            st_next.trigger = 16'h0000;
          end
          st_next.now_active = 1'b0;
        end
      end
      default: begin
        st_next.state = clean_sched_pkg::CLEAN_IDLE;
      end
    endcase

    // After the sequencer, so a new match wins over the pending clear
    if (hour_event) begin
      st_next.hour_seen = calc.hour;
      st_next.seen_valid = 1'b1;
      if (st_reg.time_valid && any_slot) begin
        st_next.sched_pend = 1'b1;
      end
    end

    if (REG_WR) begin
      st_next.ack = 1'b1;
      st_next.stage_valid = 1'b0;
      case (REG_ADDR)
        `ADDR_ZONE_OFFSET: begin
          if (wr_single) begin
            st_next.zone = REG_WDATA;
            st_next.nv_store = 1'b1;
            st_next.div_start = 1'b1;
            st_next.seen_valid = 1'b0;
          end else begin
            st_next.err = 1'b1;
          end
        end
        `ADDR_EPOCH_HI: begin
          if (wr_multi) begin
            st_next.epoch_stage = REG_WDATA;
            st_next.stage_valid = 1'b1;
          end else begin
            st_next.err = 1'b1;
          end
        end
        `ADDR_EPOCH_LO: begin
          if (load_time) begin
            // High word first, as the value travels big-endian
            st_next.epoch = {st_reg.epoch_stage, REG_WDATA};
            st_next.tick_cnt = 32'h0000_0000;
            st_next.time_valid = 1'b1;
            st_next.div_start = 1'b1;
            st_next.seen_valid = 1'b0;
          end else begin
            st_next.err = 1'b1;
          end
        end
        `ADDR_HOUR_A, `ADDR_HOUR_B, `ADDR_HOUR_C: begin
          if (wr_single || wr_multi) begin
            st_next.nv_store = 1'b1;
            if (REG_ADDR == `ADDR_HOUR_A) begin
              st_next.hour_a = REG_WDATA;
            end else if (REG_ADDR == `ADDR_HOUR_B) begin
              st_next.hour_b = REG_WDATA;
            end else begin
              st_next.hour_c = REG_WDATA;
            end
          end else begin
            st_next.err = 1'b1;
          end
        end
        `ADDR_TRIGGER: begin
          if (trig_write) begin
            // A write in the cycle the clean ends still wins over the self clear
            st_next.trigger = REG_WDATA;
            if (REG_WDATA == `TRIGGER_VALUE) begin
              st_next.now_pend = 1'b1;
            end
          end else begin
            st_next.err = 1'b1;
          end
        end
        default: begin
          st_next.err = 1'b1;
        end
      endcase
    end else if (REG_RD) begin
      st_next.ack = 1'b1;
      case (REG_ADDR)
        `ADDR_ZONE_OFFSET:   st_next.rdata = st_reg.zone;
        `ADDR_EPOCH_HI:      st_next.rdata = st_reg.epoch[31:16];
        `ADDR_EPOCH_LO:      st_next.rdata = st_reg.epoch[15:0];
        `ADDR_LAST_CLEAN_HI: st_next.rdata = st_reg.last_time[31:16];
        `ADDR_LAST_CLEAN_LO: st_next.rdata = st_reg.last_time[15:0];
        `ADDR_PUMP_LOAD:     st_next.rdata = st_reg.pump;
        `ADDR_TEMPERATURE:   st_next.rdata = TEMP_IN;
        `ADDR_HUMIDITY:      st_next.rdata = HUMID_IN;
        `ADDR_CELL_VOLTAGE:  st_next.rdata = CELL_VOLT_IN;
        `ADDR_RESERVOIR:     st_next.rdata = LIQUID_PRESENT ? `RESERVOIR_WET : `RESERVOIR_DRY;
        `ADDR_HOUR_A:        st_next.rdata = st_reg.hour_a;
        `ADDR_HOUR_B:        st_next.rdata = st_reg.hour_b;
        `ADDR_HOUR_C:        st_next.rdata = st_reg.hour_c;
        `ADDR_TRIGGER:       st_next.rdata = st_reg.trigger;
        default: begin
          st_next.rdata = 16'h0000;
          st_next.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      st_reg <= '0;
      // Reset loses the time base but restores the stored offset and slots
      st_reg.zone <= NV_IMAGE_IN[63:48];
      st_reg.hour_a <= NV_IMAGE_IN[47:32];
      st_reg.hour_b <= NV_IMAGE_IN[31:16];
      st_reg.hour_c <= NV_IMAGE_IN[15:0];
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESETN);

  no_sched_untimed_a: assert property (!st_reg.time_valid |-> !st_reg.sched_pend)
    else $error("scheduled clean pending without valid time");
  slot_hit_a: assert property (hour_event && st_reg.time_valid && any_slot |=> st_reg.sched_pend || CLEAN_RUN)
    else $error("matching hour did not request a clean");
  trigger_start_a: assert property (trig_write && REG_WDATA == `TRIGGER_VALUE && !CLEAN_RUN |=> ##1 CLEAN_RUN)
    else $error("trigger did not start a clean");
  trigger_clear_a: assert property (CLEAN_RUN && st_reg.now_active && CLEAN_DONE && !trig_write |=> st_reg.trigger == 16'h0000)
    else $error("trigger register not cleared after clean");
  time_load_a: assert property (load_time |=> st_reg.time_valid && st_reg.epoch == {$past(st_reg.epoch_stage), $past(REG_WDATA)})
    else $error("epoch time not loaded");
  second_step_a: assert property (tick && !load_time |=> st_reg.epoch == $past(st_reg.epoch) + 32'h0000_0001)
    else $error("epoch did not advance on second tick");
  clean_latch_a: assert property (CLEAN_RUN && CLEAN_DONE |=> st_reg.pump == $past(PUMP_LOAD) && st_reg.last_time == $past(st_reg.start_time))
    else $error("clean result not latched");
  zone_write_a: assert property (wr_single && REG_ADDR == `ADDR_ZONE_OFFSET |=> st_reg.zone == $past(REG_WDATA) && NV_STORE)
    else $error("offset write not taken");
  slot_write_a: assert property (wr_multi && REG_ADDR == `ADDR_HOUR_B |=> st_reg.hour_b == $past(REG_WDATA))
    else $error("slot write not taken");
  reservoir_code_a: assert property (REG_RD && !REG_WR && REG_ADDR == `ADDR_RESERVOIR |=> REG_ACK && REG_RDATA == ($past(LIQUID_PRESENT) ? 16'h0000 : 16'h0003))
    else $error("reservoir code wrong");
  last_time_read_a: assert property (REG_RD && !REG_WR && REG_ADDR == `ADDR_LAST_CLEAN_HI |=> REG_RDATA == $past(st_reg.last_time[31:16]))
    else $error("status block read wrong");

  // Bus answers, refusals and held results
  ack_answer_a: assert property ((REG_RD || REG_WR) |=> REG_ACK)
    else $error("request not answered");
  idle_no_ack_a: assert property (!REG_RD && !REG_WR |=> !REG_ACK)
    else $error("answer without request");
  err_with_ack_a: assert property (REG_ERR |-> REG_ACK)
    else $error("refusal without answer");
  unmapped_read_a: assert property (REG_RD && !REG_WR && REG_ADDR == 16'h0000
    |=> REG_ERR && REG_RDATA == 16'h0000)
    else $error("unmapped read not refused");
  zone_refused_a: assert property (wr_multi && REG_ADDR == `ADDR_ZONE_OFFSET
    |=> REG_ERR && $stable(st_reg.zone))
    else $error("offset taken by wrong function");
  lone_low_a: assert property (wr_multi && REG_ADDR == `ADDR_EPOCH_LO
    && !st_reg.stage_valid |=> REG_ERR && $stable(st_reg.time_valid))
    else $error("low time word taken alone");
  untimed_idle_a: assert property (!TIME_VALID && !st_reg.now_pend
    && !CLEAN_RUN |=> !CLEAN_RUN)
    else $error("clean started before time was written");
  time_kept_a: assert property (TIME_VALID |=> TIME_VALID)
    else $error("time validity lost");
  run_holds_a: assert property (CLEAN_RUN && !CLEAN_DONE |=> CLEAN_RUN)
    else $error("clean ended without done");
  status_hold_a: assert property (!(CLEAN_RUN && CLEAN_DONE)
    |=> $stable(st_reg.pump) && $stable(st_reg.last_time))
    else $error("clean result changed between cleans");
  trigger_hold_a: assert property (CLEAN_RUN && !CLEAN_DONE && !trig_write
    |=> $stable(st_reg.trigger))
    else $error("trigger changed during clean");
  slot_store_a: assert property (wr_multi && REG_ADDR == `ADDR_HOUR_C
    |=> NV_STORE && st_reg.hour_c == $past(REG_WDATA))
    else $error("slot write not stored");
endmodule
`default_nettype wire

// ==== tb/scada_master_model.sv ====
// Supervisory register master driving the cleaning controller's register port.
// Assumes each request is taken on one edge and answered by REG_ACK from that same edge.
`timescale 1ns/1ps
`default_nettype none
module scada_master_model (
  input  wire logic        CORE_CLK,
  output logic             REG_RD,
  output logic             REG_WR,
  output logic      [7:0]  REG_FUNC,
  output logic      [15:0] REG_ADDR,
  output logic      [15:0] REG_WDATA,
  input  wire logic [15:0] REG_RDATA,
  input  wire logic        REG_ACK,
  input  wire logic        REG_ERR
);
  logic pump_alarm;
  logic moisture_alarm;

  initial begin
    REG_RD = 1'b0;
    REG_WR = 1'b0;
    REG_FUNC = 8'h00;
    REG_ADDR = 16'h0000;
    REG_WDATA = 16'h0000;
    pump_alarm = 1'b0;
    moisture_alarm = 1'b0;
  end

  // One request in flight; write data is scrambled on release so stale values never match
  task automatic access(input logic wr, input logic [7:0] func, input logic [15:0] addr,
                        input logic [15:0] wdata, output logic [15:0] rdata,
                        output logic ack, output logic err);
    @(posedge CORE_CLK);
    #1;
    REG_WR = wr;
    REG_RD = !wr;
    REG_FUNC = func;
    REG_ADDR = addr;
    REG_WDATA = wdata;
    @(posedge CORE_CLK);
    #1;
    REG_WR = 1'b0;
    REG_RD = 1'b0;
    REG_WDATA = ~wdata;
    ack = REG_ACK;
    err = REG_ERR;
    rdata = REG_RDATA;
    if (!wr && addr == 16'h002a) pump_alarm = (REG_RDATA < 16'h003c);
    if (!wr && addr == 16'h002c) moisture_alarm = (REG_RDATA > 16'h005f);
  endtask
endmodule
`default_nettype wire

// ==== tb/clean_schedule_register_slave_bench.sv ====
// Self-checking bench for the cleaning schedule register slave.
// Assumes the master model for register traffic; the pump side is played here.
`timescale 1ns/1ps
`default_nettype none
module clean_schedule_register_slave_bench;
  localparam int unsigned SEC = 100;
  logic        core_clk;
  logic        resetn;
  logic        clean_done;
  logic        liquid;
  logic [15:0] pump_load;
  logic [15:0] temp_in;
  logic [15:0] humid_in;
  logic [15:0] volt_in;
  logic [63:0] nv_in;
  logic        reg_rd;
  logic        reg_wr;
  logic [7:0]  reg_func;
  logic [15:0] reg_addr;
  logic [15:0] reg_wdata;
  logic [15:0] rdata;
  logic        ack;
  logic        err;
  logic        clean_run;
  logic [63:0] nv_img;
  logic        nv_store;
  logic        time_valid;
  int          bad_count;
  int          comparisons;
  logic [15:0] m_zone;
  logic [15:0] m_slot [0:2];
  logic [15:0] m_trig;
  logic [15:0] m_pump;
  logic [31:0] m_last;
  logic [31:0] epoch;

  always #2.5 core_clk = ~core_clk;

  clean_schedule_register_slave #(.SEC_CYCLES(SEC)) dut_u (
    .CORE_CLK(core_clk), .RESETN(resetn), .REG_RD(reg_rd), .REG_WR(reg_wr),
    .REG_FUNC(reg_func), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata),
    .REG_ACK(ack), .REG_ERR(err), .CLEAN_RUN(clean_run), .CLEAN_DONE(clean_done),
    .PUMP_LOAD(pump_load), .TEMP_IN(temp_in), .HUMID_IN(humid_in), .CELL_VOLT_IN(volt_in),
    .LIQUID_PRESENT(liquid), .NV_IMAGE_IN(nv_in), .NV_IMAGE(nv_img), .NV_STORE(nv_store),
    .TIME_VALID(time_valid)
  );

  scada_master_model master_u (
    .CORE_CLK(core_clk), .REG_RD(reg_rd), .REG_WR(reg_wr), .REG_FUNC(reg_func),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .REG_ACK(ack),
    .REG_ERR(err)
  );

  task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic check_flag(input logic got, input logic exp);
    check_val({63'h0, got}, {63'h0, exp});
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  function automatic logic [15:0] model_read(input logic [15:0] a);
    case (a)
      16'h000d: return m_zone;
      16'h0028: return m_last[31:16];
      16'h0029: return m_last[15:0];
      16'h002a: return m_pump;
      16'h002b: return temp_in;
      16'h002c: return humid_in;
      16'h002d: return volt_in;
      16'h002e: return liquid ? 16'h0000 : 16'h0003;
      16'h0032: return m_slot[0];
      16'h0033: return m_slot[1];
      16'h0034: return m_slot[2];
      16'h0035: return m_trig;
      default: return 16'h0000;
    endcase
  endfunction

  // Signed offset widened first so negative zones do not wrap
  function automatic logic [15:0] local_hour(input logic [31:0] t, input logic [15:0] z);
    longint s;
    s = longint'(t) + longint'($signed(z)) * 3600;
    return 16'((s / 3600) % 24);
  endfunction

  task automatic xfer(input logic wr, input logic [7:0] f, input logic [15:0] a,
                      input logic [15:0] d, input logic [15:0] exp, input logic exp_err);
    logic [15:0] rd;
    logic        k;
    logic        e;
    master_u.access(wr, f, a, d, rd, k, e);
    check_flag(k, 1'b1);
    check_flag(e, exp_err);
    if (!wr) check_val(rd, exp);
  endtask

  task automatic rd_reg(input logic [15:0] a);
    xfer(1'b0, 8'h03, a, 16'h0000, model_read(a), 1'b0);
  endtask

  task automatic write_epoch(input logic [31:0] t);
    xfer(1'b1, 8'h16, 16'h0014, t[31:16], 16'h0000, 1'b0);
    xfer(1'b1, 8'h16, 16'h0015, t[15:0], 16'h0000, 1'b0);
  endtask

  task automatic serve_clean(input logic [31:0] start, input logic manual);
    int n;
    n = 0;
    while (clean_run !== 1'b1 && n < 200) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check_flag(clean_run, 1'b1);
    if (clean_run !== 1'b1) conclude();
    repeat ($urandom_range(8, 1)) @(posedge core_clk);
    #1;
    pump_load = 16'($urandom);
    clean_done = 1'b1;
    @(posedge core_clk);
    #1;
    clean_done = 1'b0;
    check_flag(clean_run, 1'b0);
    m_pump = pump_load;
    m_last = start;
    if (manual) m_trig = 16'h0000;
  endtask

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      seen = seen | clean_run;
    end
    check_flag(seen, 1'b0);
  endtask

  task automatic do_reset(input logic [63:0] nv);
    @(posedge core_clk);
    #1;
    resetn = 1'b0;
    nv_in = nv;
    repeat (5) @(posedge core_clk);
    #1;
    check_val(nv_img, nv);
    check_flag(time_valid, 1'b0);
    resetn = 1'b1;
    {m_zone, m_slot[0], m_slot[1], m_slot[2]} = nv;
    m_trig = 16'h0000;
    m_pump = 16'h0000;
    m_last = 32'h0000_0000;
  endtask

  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    clean_done = 1'b0;
    liquid = 1'b1;
    pump_load = 16'h0000;
    nv_in = 64'h0;
    bad_count = 0;
    comparisons = 0;
    void'($urandom(36));
    temp_in = 16'($urandom);
    humid_in = 16'($urandom);
    volt_in = 16'($urandom);
    epoch = 32'h640b_0a3a;
    // Slot on hour zero matches the lost time base, yet nothing may start
    do_reset({16'h0000, 16'h0000, 16'h0019, 16'h0019});
    quiet(300);
    // One seven-word sweep from 40 stands for a poll; spacing is compressed
    for (int a = 16'h0028; a <= 16'h002e; a++) begin
      rd_reg(16'(a));
    end
    check_flag(master_u.moisture_alarm, humid_in > 16'h005f);
    liquid = 1'b0;
    rd_reg(16'h002e);
    $display("test reset_status done");
    xfer(1'b1, 8'h16, 16'h000d, 16'h0001, 16'h0000, 1'b1);
    xfer(1'b1, 8'h06, 16'h002a, 16'h0001, 16'h0000, 1'b1);
    xfer(1'b0, 8'h03, 16'h0000, 16'h0000, 16'h0000, 1'b1);
    xfer(1'b1, 8'h16, 16'h0015, 16'h0001, 16'h0000, 1'b1);
    xfer(1'b1, 8'h10, 16'h0032, 16'h0001, 16'h0000, 1'b1);
    rd_reg(16'h000d);
    rd_reg(16'h0032);
    $display("test refusals done");
    m_zone = 16'hfff9;
    xfer(1'b1, 8'h06, 16'h000d, m_zone, 16'h0000, 1'b0);
    check_flag(nv_store, 1'b1);
    rd_reg(16'h000d);
    m_slot = '{local_hour(epoch, m_zone), 16'h0019, 16'h0019};
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, 8'h16, 16'h0032 + 16'(i), m_slot[i], 16'h0000, 1'b0);
    end
    check_val(nv_img, {m_zone, m_slot[0], m_slot[1], m_slot[2]});
    write_epoch(epoch);
    check_flag(time_valid, 1'b1);
    serve_clean(epoch, 1'b0);
    for (int a = 16'h0028; a <= 16'h002a; a++) begin
      rd_reg(16'(a));
    end
    check_flag(master_u.pump_alarm, m_pump < 16'h003c);
    quiet(300);
    $display("test schedule done");
    for (int i = 0; i < 3; i++) begin
      m_slot[i] = 16'h0019;
      xfer(1'b1, 8'h16, 16'h0032 + 16'(i), m_slot[i], 16'h0000, 1'b0);
    end
    epoch = epoch + 32'd100;
    write_epoch(epoch);
    quiet(350);
    epoch = epoch + 32'd3;
    xfer(1'b0, 8'h03, 16'h0014, 16'h0000, epoch[31:16], 1'b0);
    xfer(1'b0, 8'h03, 16'h0015, 16'h0000, epoch[15:0], 1'b0);
    $display("test time_base done");
    m_trig = 16'h00ff;
    xfer(1'b1, 8'h06, 16'h0035, m_trig, 16'h0000, 1'b0);
    check_flag(clean_run, 1'b0);
    @(posedge core_clk);
    #1;
    check_flag(clean_run, 1'b1);
    rd_reg(16'h0035);
    serve_clean(epoch, 1'b1);
    for (int a = 16'h0028; a <= 16'h002a; a++) begin
      rd_reg(16'(a));
    end
    check_flag(master_u.pump_alarm, m_pump < 16'h003c);
    rd_reg(16'h0035);
    $display("test manual done");
    conclude();
  end
endmodule
`default_nettype wire
